// *** dv/smbs_monitor.sv ***
`timescale 1ns/100ps
module smbs_monitor
    import smbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load_config_command,
    input wire logic read_cmd,
    input wire logic write_cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic beat_valid,
    input wire logic beat_ready,
    input wire smbs_beat_t beat,
    input wire logic cmd_ready,
    input wire logic busy,
    input wire smbs_mode_t mode,
    input wire logic mode_reserved,
    input wire logic [COL_W-1:0] col_addr,
    input wire logic bank_sel,
    input wire logic write_strobe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // a load only counts while no burst runs; reserved size, policy or page+interleave
    wire ld = load_config_command && !busy;
    wire [2:0] sz = addr[2:0];
    wire rsv = (sz > BSZ_8 && sz != BSZ_PAGE) || (sz == BSZ_PAGE && addr[3])
        || (addr[11:9] != WP_BURST && addr[11:9] != WP_SINGLE);
    a_strobe_one_cycle: assert property (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    a_strobe_has_cause: assert property (write_strobe |-> $past(write_cmd && !read_cmd))
        else $error("write strobe without write command");
    a_write_start: assert property (write_strobe |->
        col_addr == $past(addr[7:0]) && bank_sel == $past(addr[BANK_BIT]))
        else $error("write start not from command cycle");
    a_size_order: assert property (ld |=> mode.burst_size_field == $past(sz)
        && mode.burst_order_field == $past(addr[3])) else $error("size or order not loaded");
    a_write_policy: assert property (ld |=>
        mode.single_write == ($past(addr[11:9]) == WP_SINGLE)) else $error("policy not loaded");
    a_reserved_flag: assert property (ld |=> mode_reserved == $past(rsv))
        else $error("reserved flag wrong");
    a_load_settle: assert property (ld |=> !cmd_ready)
        else $error("command accepted right after load");
    a_beat_hold: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat))
        else $error("beat dropped while stalled");
    c_write: cover property (write_strobe);
    c_load: cover property (ld);
    c_stall: cover property (beat_valid && !beat_ready);
endmodule
bind smbs_sequencer smbs_monitor smbs_monitor_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .load_config_command(load_config_command), .read_cmd(read_cmd), .write_cmd(write_cmd),
    .addr(addr), .beat_valid(beat_valid), .beat_ready(beat_ready), .beat(beat),
    .cmd_ready(cmd_ready), .busy(busy), .mode(mode), .mode_reserved(mode_reserved),
    .col_addr(col_addr), .bank_sel(bank_sel), .write_strobe(write_strobe));

// *** dv/smbs_sink.sv ***
`timescale 1ns/100ps
module smbs_sink (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic slow,
    output logic beat_ready
);
    // slow mode is ready every other cycle so the fifo backs up and refuses
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) beat_ready <= 1'b0;
        else beat_ready <= slow ? !beat_ready : 1'b1;
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb
    import smbs_pkg::*;
;
    logic clk_sys = 1'b0, reset_n = 1'b0, load_config_command = 1'b0, read_cmd = 1'b0;
    logic write_cmd = 1'b0, stop_cmd = 1'b0, slow = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wr_data = 16'h0000, w0;
    logic beat_valid, beat_ready, cmd_ready, busy, mode_reserved, bank_sel, write_strobe;
    logic [7:0] col_addr;
    smbs_beat_t beat;
    smbs_mode_t mode;
    int miscompares = 0, n_compared = 0;
    smbs_sequencer smbs_sequencer_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .load_config_command(load_config_command), .read_cmd(read_cmd), .write_cmd(write_cmd),
        .stop_cmd(stop_cmd), .addr(addr), .wr_data(wr_data), .beat_valid(beat_valid),
        .beat_ready(beat_ready), .beat(beat), .cmd_ready(cmd_ready), .busy(busy), .mode(mode),
        .mode_reserved(mode_reserved), .col_addr(col_addr), .bank_sel(bank_sel),
        .write_strobe(write_strobe));
    smbs_sink smbs_sink_i (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
        .beat_ready(beat_ready));
    initial forever #10 clk_sys = ~clk_sys;
    // free-running data: beat k of a write carries the command word plus k
    always @(posedge clk_sys) wr_data <= wr_data + 16'h0001;
    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // idle means no burst, empty fifo and settle time over
    task automatic wait_idle();
        int t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (!(busy === 1'b0 && beat_valid === 1'b0 && cmd_ready === 1'b1) && t < 2000);
        if (t >= 2000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic load(input logic [11:0] a);
        wait_idle();
        load_config_command <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        load_config_command <= 1'b0;
        @(negedge clk_sys);
    endtask
    function automatic logic [7:0] ecol(input logic [7:0] s, input int l, input logic il,
        input int k);
        logic [7:0] m = 8'(l - 1);
        if (il) return s ^ 8'(k);
        return (s & ~m) | ((s + 8'(k)) & m);
    endfunction
    task automatic run(input logic wr, input logic [7:0] s, input logic b, input int l,
        input logic il, input int n);
        int k, t;
        wait_idle();
        addr <= {b, 3'h0, s};
        if (wr) write_cmd <= 1'b1;
        else read_cmd <= 1'b1;
        @(posedge clk_sys);
        w0 = wr_data;
        write_cmd <= 1'b0;
        read_cmd <= 1'b0;
        @(posedge clk_sys);
        chk(16'({write_strobe, bank_sel, col_addr}), 16'({wr, b, s}));
        for (k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(posedge clk_sys);
                t++;
            end while (!(beat_valid === 1'b1 && beat_ready === 1'b1) && t < 600);
            if (t >= 600) begin
                miscompares++;
                tally_and_finish();
            end
            chk(16'(beat.col), 16'(ecol(s, l, il, k)));
            chk(16'(beat.bank), 16'(b));
            chk(16'(beat.write), 16'(wr));
            if (wr && !slow) chk(beat.data, w0 + 16'(k));
        end
    endtask
    task automatic t_orders();
        for (int i = 0; i < 8; i++) begin
            load({3'h0, 5'h02, i[0], i[3:1]});
            chk(16'(mode), 16'({1'b0, 3'h2, i[0], i[3:1]}));
            run(1'b0, 8'h5D, 1'b0, 1 << i[3:1], i[0], 1 << i[3:1]);
            run(1'b1, 8'hA3, 1'b1, 1 << i[3:1], i[0], 1 << i[3:1]);
        end
    endtask
    task automatic t_single();
        load({WP_SINGLE, 5'h03, 1'b0, BSZ_8});
        run(1'b1, 8'h17, 1'b1, 1, 1'b0, 1);
        repeat (6) @(negedge clk_sys);
        chk(16'(beat_valid), 16'h0000);
        run(1'b0, 8'h17, 1'b1, 8, 1'b0, 8);
    endtask
    task automatic t_page();
        load({3'h0, 5'h02, 1'b0, BSZ_PAGE});
        slow <= 1'b1;
        run(1'b0, 8'hFE, 1'b1, 256, 1'b0, 258);
        stop_cmd <= 1'b1;
        @(posedge clk_sys);
        stop_cmd <= 1'b0;
        slow <= 1'b0;
    endtask
    task automatic t_reserved();
        logic [12:0] tbl [4] = '{13'h1005, 13'h100F, 13'h1400, 13'h0823};
        foreach (tbl[j]) begin
            load(tbl[j][11:0]);
            chk(16'(mode_reserved), 16'(tbl[j][12]));
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk(16'(mode), 16'h0000);
        t_orders();
        t_single();
        t_page();
        t_reserved();
        tally_and_finish();
    end
endmodule

// *** verilog/smbs_fifo.sv ***
`timescale 1ns/100ps
module smbs_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // full/empty straight from the occupancy count
    assign in_ready = cnt_q < (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset; out_data is qualified by out_valid
    always_ff @(posedge clk_sys) begin
        if (push) mem_q[wr_q] <= in_data;
    end
endmodule

// *** verilog/smbs_pkg.sv ***
package smbs_pkg;
    // address and column widths, bank bit and mode word bit positions (address pins at the load command)
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_BIT = 11;
    localparam int BURST_SIZE_LSB = 0;
    localparam int BURST_ORDER_BIT = 3;
    localparam int READ_LATENCY_LSB = 4;
    localparam int WRITE_POLICY_LSB = 9;
    // burst size codes
    localparam logic [2:0] BSZ_1 = 3'h0;
    localparam logic [2:0] BSZ_2 = 3'h1;
    localparam logic [2:0] BSZ_4 = 3'h2;
    localparam logic [2:0] BSZ_8 = 3'h3;
    localparam logic [2:0] BSZ_PAGE = 3'h7;
    // write policy codes on pins 11..9
    localparam logic [2:0] WP_BURST = 3'h0;
    localparam logic [2:0] WP_SINGLE = 3'h4;
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
    localparam logic [8:0] PAGE_BEATS = 9'h100;
    localparam int SETTLE_CYCLES = 2;

    typedef struct packed {
        logic single_write;
        logic [2:0] read_latency_field;
        logic burst_order_field;
        logic [2:0] burst_size_field;
    } smbs_mode_t;

    // one beat handed to the array side
    typedef struct packed {
        logic write;
        logic bank;
        logic [COL_W-1:0] col;
        logic [15:0] data;
    } smbs_beat_t;
endpackage

// *** verilog/smbs_sequencer.sv ***
`timescale 1ns/100ps
module smbs_sequencer
    import smbs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load_config_command,
    input wire logic read_cmd,
    input wire logic write_cmd,
    input wire logic stop_cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    output logic beat_valid,
    input wire logic beat_ready,
    output smbs_beat_t beat,
    output logic cmd_ready,
    output logic busy,
    output smbs_mode_t mode,
    output logic mode_reserved,
    output logic [COL_W-1:0] col_addr,
    output logic bank_sel,
    output logic write_strobe
);
    typedef enum logic [1:0] {SMBS_IDLE, SMBS_READ, SMBS_WRITE} smbs_state_t;

    smbs_state_t state_q, state_d;
    smbs_mode_t mode_q, mode_d;
    logic reserved_q, reserved_d;
    logic [COL_W-1:0] start_q;
    logic bank_q;
    logic [8:0] beat_q, beat_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [DATA_W-1:0] data_q;
    logic strobe_q, strobe_d;
    logic vld_q;
    logic [1:0] settle_q;
    logic fifo_ready;
    logic start_was_wr_q;

    // decode of the mode word at a config load
    wire [2:0] size_in = addr[BURST_SIZE_LSB +: 3];
    wire [2:0] policy_in = addr[WRITE_POLICY_LSB +: 3];
    wire order_in = addr[BURST_ORDER_BIT];
    wire size_ok = (size_in <= BSZ_8) || (size_in == BSZ_PAGE && !order_in);
    wire policy_ok = (policy_in == WP_BURST) || (policy_in == WP_SINGLE);
    wire load_go = load_config_command && state_q == SMBS_IDLE;

    // burst length in beats from the held size code
    wire [8:0] blen = (mode_q.burst_size_field == BSZ_PAGE) ? PAGE_BEATS :
        (9'h001 << mode_q.burst_size_field[1:0]);
    wire [7:0] mask = 8'(blen - 9'h001);
    wire [7:0] beat8 = beat_q[7:0];
    wire [7:0] seq_low = (start_q + beat8) & mask;
    wire [7:0] ilv_low = (start_q ^ beat8) & mask;
    wire [7:0] next_col = (start_q & ~mask) |
        (mode_q.burst_order_field ? ilv_low : seq_low);
    // single write stores one word only, whatever the size
    wire one_write = mode_q.single_write || blen == 9'h001;
    wire last_beat = (beat_q + 9'h001 >= blen) && blen != PAGE_BEATS;

    // commands are refused while the fifo is full or the mode settles
    assign cmd_ready = fifo_ready && settle_q == 2'h0;
    // a beat refused by a full fifo stays put; stepping on would lose a column
    wire adv = !vld_q || fifo_ready;
    wire cmd_go = cmd_ready && state_q == SMBS_IDLE && !load_config_command;
    wire start_rd = cmd_go && read_cmd;
    wire start_wr = cmd_go && write_cmd && !read_cmd;

    // mode register load and reserved-code flag
    always_comb begin
        mode_d = mode_q;
        reserved_d = reserved_q;
        if (load_go) begin
            mode_d.burst_size_field = size_in;
            mode_d.burst_order_field = order_in;
            mode_d.read_latency_field = addr[READ_LATENCY_LSB +: 3];
            mode_d.single_write = policy_in == WP_SINGLE;
            reserved_d = !(size_ok && policy_ok);
        end
    end

    // burst sequencing: the command beat is beat 0 of the burst
    always_comb begin
        state_d = state_q;
        beat_d = beat_q;
        col_d = col_q;
        strobe_d = 1'b0;
        case (state_q)
            SMBS_IDLE: begin
                if (start_rd || start_wr) begin
                    col_d = addr[COL_W-1:0];
                    beat_d = 9'h001;
                    strobe_d = start_wr;
                    if (start_rd && blen != 9'h001) state_d = SMBS_READ;
                    if (start_wr && !one_write) state_d = SMBS_WRITE;
                end
            end
            SMBS_READ, SMBS_WRITE: begin
                if (stop_cmd) begin
                    state_d = SMBS_IDLE;
                end else if (adv) begin
                    col_d = next_col;
                    beat_d = beat_q + 9'h001;
                    if (last_beat) state_d = SMBS_IDLE;
                end
            end
            default: state_d = SMBS_IDLE;
        endcase
    end

    // registers; full page wraps via 8-bit column arithmetic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SMBS_IDLE;
            mode_q <= '0;
            reserved_q <= 1'b0;
            beat_q <= '0;
            col_q <= '0;
            strobe_q <= 1'b0;
            settle_q <= '0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            reserved_q <= reserved_d;
            beat_q <= beat_d;
            col_q <= col_d;
            strobe_q <= strobe_d;
            settle_q <= load_go ? 2'(SETTLE_CYCLES) :
                (settle_q != 2'h0 ? settle_q - 2'h1 : 2'h0);
        end
    end

    // command-cycle capture of start, bank and first write word
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_q <= '0;
            bank_q <= 1'b0;
            data_q <= '0;
            vld_q <= 1'b0;
        end else begin
            if (start_rd || start_wr) begin
                start_q <= addr[COL_W-1:0];
                bank_q <= addr[BANK_BIT];
            end
            if (start_wr || (state_q == SMBS_WRITE && adv)) data_q <= wr_data;
            vld_q <= (start_rd || start_wr) ||
                (state_q != SMBS_IDLE && !stop_cmd && adv) || (vld_q && !fifo_ready);
        end
    end

    // beat stream into the fifo; each cycle one beat at most
    wire in_valid = vld_q;
    smbs_beat_t in_beat;
    assign in_beat.write = strobe_q || state_q == SMBS_WRITE ||
        (state_q == SMBS_IDLE && vld_q && start_was_wr_q);
    assign in_beat.bank = bank_q;
    assign in_beat.col = col_q;
    assign in_beat.data = data_q;

    // remembers the command kind for the last beat, pushed after the burst went idle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) start_was_wr_q <= 1'b0;
        else if (start_rd || start_wr) start_was_wr_q <= start_wr;
    end

    smbs_fifo #(
        .WIDTH($bits(smbs_beat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(in_valid),
        .in_ready(fifo_ready),
        .in_data(in_beat),
        .out_valid(beat_valid),
        .out_ready(beat_ready),
        .out_data(beat)
    );

    // status outputs, all from flip-flops
    assign busy = state_q != SMBS_IDLE;
    assign mode = mode_q;
    assign mode_reserved = reserved_q;
    assign col_addr = col_q;
    assign bank_sel = bank_q;
    assign write_strobe = strobe_q;
endmodule
